// ===== common/ddbg_pkg.sv
package ddbg_pkg;
  // Register offsets, lower 16 bits of the peripheral address
  localparam logic [15:0] OFF_D_DIRECTION = 16'hfebc;
  localparam logic [15:0] OFF_E_DIRECTION = 16'hfebd;
  localparam logic [15:0] OFF_D_PIN_STATE = 16'hff5c;
  localparam logic [15:0] OFF_E_PIN_STATE = 16'hff5d;
  localparam logic [15:0] OFF_D_OUT_LATCH = 16'hff6c;
  localparam logic [15:0] OFF_E_OUT_LATCH = 16'hff6d;
  localparam logic [15:0] OFF_D_PULLUP    = 16'hff73;
  localparam logic [15:0] OFF_E_PULLUP    = 16'hff74;
  // Reset values
  localparam logic [7:0]  RST_REG         = 8'h00;
  // Value returned for write-only or unmapped reads
  localparam logic [7:0]  READ_FILLER     = 8'h00;
  // Operating mode codes that make the ports plain I/O
  localparam logic [2:0]  MODE_SINGLE_A   = 3'h3;
  localparam logic [2:0]  MODE_SINGLE_B   = 3'h7;
endpackage

// ===== core/ddbg_gpio.sv
`timescale 1ns/1ps
// Overview of operation
// - Port D pin-state register read-only, ignores writes
// - Port D read: latch if output, pin else
// - Port D pin-state follows pins after reset
// - Port D pull-up: modes 3/7, input, enabled
// - Port D pull-up register cleared by reset
// - Other modes: port D is data bus
// - Modes 3/7: port D direction per bit
// - Other modes: port D pull-ups off
// - Port E direction write-only, reads give filler
// - Port E direction cleared by reset
// - Bus modes, 8-bit bus: port E I/O
// - Bus modes, 16-bit bus: port E data
// - Modes 3/7: port E direction per bit
// - Port E output latch read/write, cleared
// - Port E pin-state register read-only
// - Port E read: latch if output, pin else
// - Port E pin-state follows pins after reset
// - Port E pull-up gated by mode, width
// - Port E pull-up register cleared by reset
// - Port D output latch read/write register
module ddbg_gpio
(
  input  wire logic        clk,            // System clock, 50 MHz
  input  wire logic        reset,          // Power-on reset or hardware standby
  input  wire logic [15:0] regAddr,        // Register address, lower 16 bits
  input  wire logic [7:0]  regWdata,       // Write data
  input  wire logic        regWrite,       // Write strobe
  input  wire logic        regRead,        // Read strobe
  output logic      [7:0]  regRdata,       // Read data, cycle after the strobe
  input  wire logic [2:0]  opMode,         // Operating mode pins
  input  wire logic        wideBus,        // 16-bit external bus selected
  input  wire logic [7:0]  busDataHiOut,   // Bus data to drive on port D
  input  wire logic        busDataHiOe,    // Bus controller drives port D
  input  wire logic [7:0]  busDataLoOut,   // Bus data to drive on port E
  input  wire logic        busDataLoOe,    // Bus controller drives port E
  output logic      [7:0]  busDataHiIn,    // Synchronised port D level to bus
  output logic      [7:0]  busDataLoIn,    // Synchronised port E level to bus
  input  wire logic [7:0]  portDIn,        // Port D pin levels
  output logic      [7:0]  portDOut,       // Port D pin drive value
  output logic      [7:0]  portDOe,        // Port D drive enables
  output logic      [7:0]  portDPullup,    // Port D pull-up enables
  input  wire logic [7:0]  portEIn,        // Port E pin levels
  output logic      [7:0]  portEOut,       // Port E pin drive value
  output logic      [7:0]  portEOe,        // Port E drive enables
  output logic      [7:0]  portEPullup     // Port E pull-up enables
);

  // Software registers
  logic [7:0] port_d_direction;       // Port D direction, 1 = output
  logic [7:0] port_d_output_latch;    // Port D output values
  logic [7:0] port_d_pullup_control;  // Port D pull-up enables
  logic [7:0] port_e_direction;       // Port E direction, 1 = output
  logic [7:0] port_e_output_latch;    // Port E output values
  logic [7:0] port_e_pullup_control;  // Port E pull-up enables

  // Pin synchronisers; first stage feeds only the second
  logic [7:0] dMeta;                  // Port D first stage
  logic [7:0] dSync;                  // Port D settled level
  logic [7:0] eMeta;                  // Port E first stage
  logic [7:0] eSync;                  // Port E settled level

  // Mode decode
  logic [2:0] modeMeta;               // Mode pins, first stage
  logic [2:0] modeSync;               // Mode pins, settled
  logic singleChip;                   // Modes 3 and 7: plain ports
  logic eIsGpio;                      // Port E usable as general I/O
  logic [7:0] port_d_pin_state;       // Read view of port D
  logic [7:0] port_e_pin_state;       // Read view of port E

  // Mode and width decode, purely combinational
  always_comb
  begin
    singleChip = (modeSync == ddbg_pkg::MODE_SINGLE_A) || (modeSync == ddbg_pkg::MODE_SINGLE_B);
    eIsGpio    = singleChip || !wideBus;
  end

  // Mode pins are strapped off-chip and not timed to clk, so they get the
  // same two flops as the port pins; a strap change lands two cycles late
  always_ff @(posedge clk)
  begin
    modeMeta <= opMode;
    modeSync <= modeMeta;
  end

  // Two-flop synchronisers on the pin inputs
  always_ff @(posedge clk)
  begin
    dMeta <= portDIn;
    dSync <= dMeta;
    eMeta <= portEIn;
    eSync <= eMeta;
  end

  // Levels handed to the bus controller
  assign busDataHiIn = dSync;
  assign busDataLoIn = eSync;

  // Port D registers; reset clears, manual reset does not reach here
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      port_d_direction      <= ddbg_pkg::RST_REG;
      port_d_output_latch   <= ddbg_pkg::RST_REG;
      port_d_pullup_control <= ddbg_pkg::RST_REG;
    end
    else if (regWrite)
    begin
      // Plain byte writes, no merge with old contents
      if (regAddr == ddbg_pkg::OFF_D_DIRECTION)
      begin
        port_d_direction <= regWdata;
      end
      else if (regAddr == ddbg_pkg::OFF_D_OUT_LATCH)
      begin
        port_d_output_latch <= regWdata;
      end
      else if (regAddr == ddbg_pkg::OFF_D_PULLUP)
      begin
        port_d_pullup_control <= regWdata;
      end
    end
  end

  // Port E registers; writes to the pin-state address fall through
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      port_e_direction      <= ddbg_pkg::RST_REG;
      port_e_output_latch   <= ddbg_pkg::RST_REG;
      port_e_pullup_control <= ddbg_pkg::RST_REG;
    end
    else if (regWrite)
    begin
      if (regAddr == ddbg_pkg::OFF_E_DIRECTION)
      begin
        port_e_direction <= regWdata;
      end
      else if (regAddr == ddbg_pkg::OFF_E_OUT_LATCH)
      begin
        port_e_output_latch <= regWdata;
      end
      else if (regAddr == ddbg_pkg::OFF_E_PULLUP)
      begin
        port_e_pullup_control <= regWdata;
      end
    end
  end

  // Pin-state views: latch for outputs, settled pin level for inputs.
  // Reset clears direction, so the view shows pins right after reset.
  always_comb
  begin
    port_d_pin_state = (port_d_direction & port_d_output_latch)
                     | (~port_d_direction & dSync);
    port_e_pin_state = (port_e_direction & port_e_output_latch)
                     | (~port_e_direction & eSync);
  end

  // Read data register; valid only in the cycle after the strobe.
  // Direction registers are write-only and read back as filler.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      regRdata <= ddbg_pkg::READ_FILLER;
    end
    else if (regRead)
    begin
      if (regAddr == ddbg_pkg::OFF_D_PIN_STATE)
      begin
        regRdata <= port_d_pin_state;
      end
      else if (regAddr == ddbg_pkg::OFF_E_PIN_STATE)
      begin
        regRdata <= port_e_pin_state;
      end
      else if (regAddr == ddbg_pkg::OFF_D_OUT_LATCH)
      begin
        regRdata <= port_d_output_latch;
      end
      else if (regAddr == ddbg_pkg::OFF_E_OUT_LATCH)
      begin
        regRdata <= port_e_output_latch;
      end
      else if (regAddr == ddbg_pkg::OFF_D_PULLUP)
      begin
        regRdata <= port_d_pullup_control;
      end
      else if (regAddr == ddbg_pkg::OFF_E_PULLUP)
      begin
        regRdata <= port_e_pullup_control;
      end
      else
      begin
        regRdata <= ddbg_pkg::READ_FILLER;
      end
    end
    else
    begin
      regRdata <= ddbg_pkg::READ_FILLER;
    end
  end

  // Port D pin drivers; in bus modes the bus controller owns the pins
  always_comb
  begin
    if (singleChip)
    begin
      portDOut = port_d_output_latch;
      portDOe  = port_d_direction;
    end
    else
    begin
      portDOut = busDataHiOut;
      portDOe  = {8{busDataHiOe}};
    end
  end

  // Port E pin drivers; in bus modes a 16-bit bus hands the pins to the bus
  always_comb
  begin
    if (eIsGpio)
    begin
      portEOut = port_e_output_latch;
      portEOe  = port_e_direction;
    end
    else
    begin
      portEOut = busDataLoOut;
      portEOe  = {8{busDataLoOe}};
    end
  end

  // Pull-ups only on input pins of a port in general I/O use.
  // Gated combinationally so a mode change drops them once modeSync takes it, two cycles late.
  always_comb
  begin
    portDPullup = singleChip ? (~port_d_direction & port_d_pullup_control)
                             : 8'h00;
    portEPullup = eIsGpio ? (~port_e_direction & port_e_pullup_control)
                          : 8'h00;
  end

  // Helper: last read address and strobe for read checks
  logic        rdPend;
  logic [15:0] rdAddr;
  always_ff @(posedge clk)
  begin
    rdPend <= regRead && !reset;
    rdAddr <= regAddr;
  end

  // Pin ownership, pull-up gating and register access; all but the reset check are off in reset
  a_d_pullup_gate: assert property (@(posedge clk) disable iff (reset)
    (singleChip && !port_d_direction[0] && port_d_pullup_control[0]) |-> portDPullup[0])
    else $error("port D pull-up not on");
  a_d_pullup_off: assert property (@(posedge clk) disable iff (reset)
    !singleChip |-> portDPullup == 8'h00)
    else $error("port D pull-up on in bus mode");
  a_e_pullup_wide: assert property (@(posedge clk) disable iff (reset)
    (!singleChip && wideBus) |-> portEPullup == 8'h00)
    else $error("port E pull-up on with wide bus");
  a_d_bus_owned: assert property (@(posedge clk) disable iff (reset)
    !singleChip |-> portDOe == {8{busDataHiOe}})
    else $error("port D not on data bus");
  a_e_bus_owned: assert property (@(posedge clk) disable iff (reset)
    (!singleChip && wideBus) |-> portEOut == busDataLoOut)
    else $error("port E not on data bus");
  a_d_gpio_dir: assert property (@(posedge clk) disable iff (reset)
    singleChip |-> portDOe == port_d_direction)
    else $error("port D direction wrong");
  a_e_gpio_dir: assert property (@(posedge clk) disable iff (reset)
    singleChip |-> portEOe == port_e_direction)
    else $error("port E direction wrong");
  a_e_narrow_io: assert property (@(posedge clk) disable iff (reset)
    (!singleChip && !wideBus) |-> portEOut == port_e_output_latch)
    else $error("port E not general I/O");
  a_d_state_read: assert property (@(posedge clk) disable iff (reset)
    (regRead && regAddr == ddbg_pkg::OFF_D_PIN_STATE) |=>
      regRdata == (($past(port_d_direction) & $past(port_d_output_latch))
                 | (~$past(port_d_direction) & $past(dSync))))
    else $error("port D pin-state read wrong");
  a_e_state_read: assert property (@(posedge clk) disable iff (reset)
    (regRead && regAddr == ddbg_pkg::OFF_E_PIN_STATE) |=>
      regRdata == (($past(port_e_direction) & $past(port_e_output_latch))
                 | (~$past(port_e_direction) & $past(eSync))))
    else $error("port E pin-state read wrong");
  a_state_nowrite: assert property (@(posedge clk) disable iff (reset)
    (regWrite && regAddr == ddbg_pkg::OFF_D_PIN_STATE) |=>
      $stable(port_d_output_latch) && $stable(port_d_direction))
    else $error("pin-state write changed state");
  a_e_dir_write: assert property (@(posedge clk) disable iff (reset)
    (regWrite && regAddr == ddbg_pkg::OFF_E_DIRECTION) |=> port_e_direction == $past(regWdata))
    else $error("port E direction write lost");
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !rdPend |-> regRdata == ddbg_pkg::READ_FILLER)
    else $error("read data outside read slot");
  a_reset_clear: assert property (@(posedge clk)
    reset |=> port_e_direction == 8'h00 && port_d_pullup_control == 8'h00
              && port_e_pullup_control == 8'h00 && port_e_output_latch == 8'h00)
    else $error("reset did not clear registers");

  // Stored registers read back unchanged, one cycle after the strobe.
  // The helper flops carry the strobe and address into the answer cycle.
  a_d_latch_read: assert property (@(posedge clk) disable iff (reset)
    (rdPend && rdAddr == ddbg_pkg::OFF_D_OUT_LATCH) |->
      regRdata == $past(port_d_output_latch))
    else $error("port D latch read wrong");
  a_d_pull_read: assert property (@(posedge clk) disable iff (reset)
    (rdPend && rdAddr == ddbg_pkg::OFF_D_PULLUP) |->
      regRdata == $past(port_d_pullup_control))
    else $error("port D pull-up read wrong");
  a_e_pull_read: assert property (@(posedge clk) disable iff (reset)
    (rdPend && rdAddr == ddbg_pkg::OFF_E_PULLUP) |->
      regRdata == $past(port_e_pullup_control))
    else $error("port E pull-up read wrong");

  // Read strobe on the port E latch; the answer comes one cycle later
  sequence s_e_latch_read;
    regRead && regAddr == ddbg_pkg::OFF_E_OUT_LATCH;
  endsequence
  a_e_latch_read: assert property (@(posedge clk) disable iff (reset)
    s_e_latch_read |=> regRdata == $past(port_e_output_latch))
    else $error("port E latch read wrong");

  // Write strobe to the port E pin-state address; nothing stored may move
  sequence s_e_state_write;
    regWrite && regAddr == ddbg_pkg::OFF_E_PIN_STATE;
  endsequence
  a_e_state_nowrite: assert property (@(posedge clk) disable iff (reset)
    s_e_state_write |=> $stable(port_e_output_latch) && $stable(port_e_direction)
                        && $stable(port_e_pullup_control))
    else $error("port E pin-state write changed state");

  // Cleared direction is what makes the view show the pins; latch is cleared too
  a_d_reset_clear: assert property (@(posedge clk)
    reset |=> port_d_direction == ddbg_pkg::RST_REG
              && port_d_output_latch == ddbg_pkg::RST_REG)
    else $error("reset did not clear port D");

endmodule // ddbg_gpio

// ===== tb/ddbg_gpio_tb_top.sv
`timescale 1ns/1ps
module ddbg_gpio_tb_top;
  logic        clk, reset, regWrite, regRead, wideBus, busDataHiOe, busDataLoOe;
  logic [15:0] regAddr;
  logic [7:0]  regWdata, regRdata, busDataHiOut, busDataLoOut, extD, extE;
  logic [7:0]  portDIn, portDOut, portDOe, portDPullup;
  logic [7:0]  portEIn, portEOut, portEOe, portEPullup;
  logic [7:0]  extEnD, extEnE, busDataHiIn, busDataLoIn; // Far side enables, bus view
  logic [2:0]  opMode;
  int          failures, n_compared;
  int          dDir, dLat, dPu, eDir, eLat, ePu; // Bench copies of the registers
  ddbg_gpio dut_u (.clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .opMode(opMode),
    .wideBus(wideBus), .busDataHiOut(busDataHiOut), .busDataHiOe(busDataHiOe),
    .busDataLoOut(busDataLoOut), .busDataLoOe(busDataLoOe), .busDataHiIn(busDataHiIn),
    .busDataLoIn(busDataLoIn), .portDIn(portDIn), .portDOut(portDOut), .portDOe(portDOe),
    .portDPullup(portDPullup), .portEIn(portEIn), .portEOut(portEOut),
    .portEOe(portEOe), .portEPullup(portEPullup));
  ddbg_pin_model pin_d_u (.clk(clk), .oe(portDOe), .drv(portDOut), .pu(portDPullup),
    .extEn(extEnD), .ext(extD), .pin(portDIn));
  ddbg_pin_model pin_e_u (.clk(clk), .oe(portEOe), .drv(portEOut), .pu(portEPullup),
    .extEn(extEnE), .ext(extE), .pin(portEIn));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Verdict, the only exit
  task automatic tally_and_finish();
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compare one byte
  task automatic chk(string nm, int exp, logic [7:0] got);
    n_compared++;
    if (got !== exp[7:0])
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp[7:0], got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(logic [15:0] a, int d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d[7:0];
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // One-cycle read strobe, data looked at in the next cycle only
  task automatic rd(string nm, logic [15:0] a, int exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(nm, exp, regRdata);
  endtask
  // Cleared state, read in mode 3
  task automatic chk_cleared();
    rd("d_latch", ddbg_pkg::OFF_D_OUT_LATCH, 0);
    rd("e_latch", ddbg_pkg::OFF_E_OUT_LATCH, 0);
    rd("d_pullup", ddbg_pkg::OFF_D_PULLUP, 0);
    rd("e_pullup", ddbg_pkg::OFF_E_PULLUP, 0);
    rd("d_pins", ddbg_pkg::OFF_D_PIN_STATE, extD);
    rd("e_pins", ddbg_pkg::OFF_E_PIN_STATE, extE);
    chk("portEOe", 0, portEOe);
  endtask
  // Pin roles for one mode and bus width
  task automatic chk_pins(int m, bit w);
    bit io;
    bit eio;
    int dPin;
    int ePin;
    io   = (m == 3 || m == 7);
    eio  = io || !w;
    // Pin level: own drive, else far side, else the pull-up it was promised
    dPin = io ? dDir & dLat | ~dDir & (extEnD & extD | ~extEnD) : busDataHiOut;
    ePin = eio ? eDir & eLat | ~eDir & (extEnE & extE | ~extEnE) : busDataLoOut;
    chk("portDOe", io ? dDir : (busDataHiOe ? 255 : 0), portDOe);
    chk("portDOut", io ? dLat : busDataHiOut, portDOut);
    chk("portDPullup", io ? ~dDir & dPu : 0, portDPullup);
    chk("portEOe", eio ? eDir : (busDataLoOe ? 255 : 0), portEOe);
    chk("portEOut", eio ? eLat : busDataLoOut, portEOut);
    chk("portEPullup", eio ? ~eDir & ePu : 0, portEPullup);
    if (io || busDataHiOe)
      chk("busDataHiIn", dPin, busDataHiIn);
    if (eio || busDataLoOe)
      chk("busDataLoIn", ePin, busDataLoIn);
    if (io)
      rd("d_pins", ddbg_pkg::OFF_D_PIN_STATE, dPin);
    if (eio)
      rd("e_pins", ddbg_pkg::OFF_E_PIN_STATE, ePin);
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h421d));
    {regWrite, regRead, wideBus, busDataHiOe, busDataLoOe} = '0;
    {regAddr, regWdata, busDataHiOut, busDataLoOut} = '0;
    {extEnD, extEnE} = '1;
    reset  = 1'b1;
    opMode = 3'h3;
    extD   = $urandom;
    extE   = $urandom;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk_cleared();
    repeat (4)
    begin
      dDir = $urandom & 255;
      dLat = $urandom & 255;
      dPu  = $urandom & 255;
      eDir = $urandom & 255;
      eLat = $urandom & 255;
      ePu  = $urandom & 255;
      // Far side lets go only of pins whose pull-up is asked for
      extEnD <= 8'(~dPu | $urandom);
      extEnE <= 8'(~ePu | $urandom);
      extD   <= 8'($urandom);
      extE   <= 8'($urandom);
      wr(ddbg_pkg::OFF_D_DIRECTION, dDir);
      wr(ddbg_pkg::OFF_D_OUT_LATCH, dLat);
      wr(ddbg_pkg::OFF_D_PULLUP, dPu);
      wr(ddbg_pkg::OFF_E_DIRECTION, eDir);
      wr(ddbg_pkg::OFF_E_OUT_LATCH, eLat);
      wr(ddbg_pkg::OFF_E_PULLUP, ePu);
      wr(ddbg_pkg::OFF_D_PIN_STATE, $urandom);
      wr(ddbg_pkg::OFF_E_PIN_STATE, $urandom);
      rd("d_latch", ddbg_pkg::OFF_D_OUT_LATCH, dLat);
      rd("e_latch", ddbg_pkg::OFF_E_OUT_LATCH, eLat);
      rd("d_pullup", ddbg_pkg::OFF_D_PULLUP, dPu);
      rd("e_pullup", ddbg_pkg::OFF_E_PULLUP, ePu);
      rd("e_dir", ddbg_pkg::OFF_E_DIRECTION, ddbg_pkg::READ_FILLER);
      rd("unmapped", 16'hff00, ddbg_pkg::READ_FILLER);
      busDataHiOut <= 8'($urandom);
      busDataLoOut <= 8'($urandom);
      {busDataHiOe, busDataLoOe} <= 2'($urandom);
      for (int m = 1; m < 8; m++)
        for (int w = 0; w < 2; w++)
        begin
          opMode  <= m[2:0];
          wideBus <= w[0];
          repeat (4) @(posedge clk);
          #1 chk_pins(m, w[0]);
        end
    end
    // Second reset in mid-run clears everything again
    opMode <= 3'h3;
    extD   <= ~extD;
    extEnD <= 8'hff;
    extEnE <= 8'hff;
    reset  <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    chk_cleared();
    tally_and_finish();
  end
endmodule // ddbg_gpio_tb_top

// ===== tb/ddbg_pin_model.sv
`timescale 1ns/1ps
// Far side pins: device drive wins, then the far driver, then the pull-up
module ddbg_pin_model
(
  input  wire logic       clk,   // System clock
  input  wire logic [7:0] oe,    // Device drive enables
  input  wire logic [7:0] drv,   // Device drive values
  input  wire logic [7:0] pu,    // Pull-up enables
  input  wire logic [7:0] extEn, // Far side drive enables
  input  wire logic [7:0] ext,   // Far side values
  output logic      [7:0] pin    // Resolved level
);
  logic [7:0] flt = 8'h00; // Floating pins wander every cycle, never hold a level
  // Toggle so an undriven read can never match by luck
  always @(posedge clk)
    flt <= ~flt;
  // Per pin resolution
  always_comb
    for (int i = 0; i < 8; i++)
      pin[i] = oe[i] ? drv[i] : extEn[i] ? ext[i] : pu[i] ? 1'b1 : flt[i];
endmodule // ddbg_pin_model
